// ==== hdl/mbtcp_server.sv ====
`timescale 1ns/10ps
`include "mbtcp_defs.svh"
// Contract
// - Seven-byte header precedes every message
// - Reply echoes request transaction identifier
// - Protocol identifier is always zero
// - Length counts unit, function, data bytes
// - Unit identifier is always zero
// - Accept codes 03,04,06,16,23,43/13; code answers 16, 23 and 43/13 with exception 04
// - Accept 101/102 with subfunctions 85/170; code answers these with exception 04
// - Read request length 6, count 1..7D
// - Read reply: byte count 2M, length 3+2M
// - Failure reply length 3, code|80, exception
// - Process data reads need 4-byte alignment
// - Single write length 6, address, value
// - Single write reply echoes the request
// - Single write targets process data objects
// - TCP port 502, one client, no CRC
// - Fields big-endian except 2B/65/66 data

module mbtcp_server
    import mbtcp_pkg::*;
#(
    parameter int MAX_REGS = 125
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire mb_byte_t rx,
    output logic rx_ready,
    output mb_byte_t tx,
    input wire logic tx_ready,
    output logic acc_req,
    output logic acc_write,
    output logic acc_input,
    output logic [15:0] acc_addr,
    output logic [15:0] acc_wdata,
    input wire logic acc_ack,
    input wire logic acc_err,
    input wire logic acc_pdo,
    input wire logic [15:0] acc_rdata
);
    localparam int IW = $clog2(MAX_REGS);

    srv_state_t state;
    mb_hdr_t hdr;
    logic [15:0] nbytes;
    logic frame_done;
    logic [15:0] regs [MAX_REGS];
    logic [IW-1:0] idx;
    logic is_exc;
    logic [7:0] exc_code;
    logic [15:0] rsp_len;
    logic [15:0] tx_idx;
    logic [7:0] next_byte;
    logic [15:0] next_idx;
    logic chk_drop;
    logic chk_exc;
    logic [7:0] chk_code;
    logic tx_go;

    // Request bytes are held off while a request is being served
    frame_capture u_capture (
        .clk_sys(clk_sys),
        .srst(srst),
        .rx(rx),
        .rx_ready(rx_ready),
        .hold(state != ST_IDLE),
        .hdr(hdr),
        .nbytes(nbytes),
        .done(frame_done)
    );

    // Request validation
    always_comb begin
        chk_drop = 1'b0;
        chk_exc = 1'b0;
        chk_code = `MB_EXC_FUNC;
        if (nbytes < `MB_HDR_BYTES + 16'h0001 || hdr.pid != `MB_PROTO_ID
            || hdr.uid != `MB_UNIT_ID
            || hdr.len != nbytes - `MB_LEN_OFS) begin
            chk_drop = 1'b1;
        end else begin
            case (hdr.fc)
                `MB_FC_RD_HOLD, `MB_FC_RD_INPUT: begin
                    if (hdr.len != `MB_REQ_LEN || hdr.word1 == 16'h0000
                        || hdr.word1 > `MB_RD_MAX || hdr.word1 > 16'(MAX_REGS)) begin
                        chk_exc = 1'b1;
                        chk_code = `MB_EXC_VALUE;
                    end
                end
                `MB_FC_WR_SINGLE: begin
                    if (hdr.len != `MB_REQ_LEN) begin
                        chk_exc = 1'b1;
                        chk_code = `MB_EXC_VALUE;
                    end
                end
                `MB_FC_WR_MULTI, `MB_FC_RW_MULTI: begin
                    chk_exc = 1'b1;
                    chk_code = `MB_EXC_FAIL;
                end
                `MB_FC_ENCAP: begin
                    chk_exc = 1'b1;
                    chk_code = (hdr.word0[15:8] == `MB_SUB_ENCAP) ? `MB_EXC_FAIL : `MB_EXC_FUNC;
                end
                `MB_FC_DICT, `MB_FC_ARRAY: begin
                    chk_exc = 1'b1;
                    chk_code = (hdr.word0[15:8] == `MB_SUB_START
                        || hdr.word0[15:8] == `MB_SUB_NEXT) ? `MB_EXC_FAIL : `MB_EXC_FUNC;
                end
                default: begin
                    chk_exc = 1'b1;
                    chk_code = `MB_EXC_FUNC;
                end
            endcase
        end
    end

    assign tx_go = tx.valid && tx_ready;

    // Server sequence
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= ST_IDLE;
            idx <= '0;
            is_exc <= 1'b0;
            exc_code <= 8'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    idx <= '0;
                    if (frame_done) begin
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    is_exc <= chk_exc;
                    exc_code <= chk_code;
                    if (chk_drop) begin
                        state <= ST_IDLE;
                    end else if (chk_exc) begin
                        state <= ST_SEND;
                    end else if (hdr.fc == `MB_FC_WR_SINGLE) begin
                        state <= ST_WRITE;
                    end else begin
                        state <= ST_READ;
                    end
                end
                ST_READ: begin
                    if (acc_ack) begin
                        if (acc_err || (acc_pdo && hdr.word0[0])) begin
                            is_exc <= 1'b1;
                            exc_code <= `MB_EXC_ADDR;
                            state <= ST_SEND;
                        end else if (16'(idx) == hdr.word1 - 16'h0001) begin
                            state <= ST_SEND;
                        end else begin
                            idx <= idx + 1'b1;
                        end
                    end
                end
                ST_WRITE: begin
                    if (acc_ack) begin
                        if (acc_err || !acc_pdo) begin
                            is_exc <= 1'b1;
                            exc_code <= `MB_EXC_ADDR;
                        end
                        state <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (tx_go && tx.last) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Read data store
    always_ff @(posedge clk_sys) begin
        if (state == ST_READ && acc_ack) begin
            regs[idx] <= acc_rdata;
        end
    end

    assign acc_req = (state == ST_READ) || (state == ST_WRITE);
    assign acc_write = (state == ST_WRITE);
    assign acc_input = (hdr.fc == `MB_FC_RD_INPUT);
    assign acc_addr = hdr.word0 + 16'(idx);
    assign acc_wdata = hdr.word1;

    // Reply length field
    always_comb begin
        if (is_exc) begin
            rsp_len = `MB_EXC_LEN;
        end else if (hdr.fc == `MB_FC_WR_SINGLE) begin
            rsp_len = `MB_REQ_LEN;
        end else begin
            rsp_len = `MB_RD_LEN_BASE + {hdr.word1[14:0], 1'b0};
        end
    end

    assign next_idx = (state == ST_SEND) ? tx_idx + 16'h0001 : 16'h0000;

    // Reply byte at a position, big-endian
    always_comb begin
        next_byte = 8'h00;
        case (next_idx)
            `MB_BYTE_TID_HI: next_byte = hdr.tid[15:8];
            `MB_BYTE_TID_LO: next_byte = hdr.tid[7:0];
            `MB_BYTE_LEN_HI: next_byte = rsp_len[15:8];
            `MB_BYTE_LEN_LO: next_byte = rsp_len[7:0];
            `MB_BYTE_FC: next_byte = is_exc ? (hdr.fc | `MB_EXC_FLAG) : hdr.fc;
            `MB_BYTE_P0: begin
                if (is_exc) begin
                    next_byte = exc_code;
                end else if (hdr.fc == `MB_FC_WR_SINGLE) begin
                    next_byte = hdr.word0[15:8];
                end else begin
                    next_byte = {hdr.word1[6:0], 1'b0};
                end
            end
            default: begin
                if (next_idx < `MB_HDR_BYTES) begin
                    next_byte = 8'h00;
                end else if (hdr.fc == `MB_FC_WR_SINGLE) begin
                    case (next_idx)
                        `MB_BYTE_P1: next_byte = hdr.word0[7:0];
                        `MB_BYTE_P2: next_byte = hdr.word1[15:8];
                        `MB_BYTE_P3: next_byte = hdr.word1[7:0];
                        default: next_byte = 8'h00;
                    endcase
                end else begin
                    next_byte = next_idx[0] ? regs[IW'((next_idx - `MB_BYTE_P1) >> 1)][15:8]
                        : regs[IW'((next_idx - `MB_BYTE_P1) >> 1)][7:0];
                end
            end
        endcase
    end

    // Transmit register; total reply size is length plus six
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx <= '0;
            tx_idx <= 16'h0000;
        end else if (state != ST_SEND) begin
            tx <= '0;
            tx_idx <= 16'h0000;
        end else if (!tx.valid || tx_go) begin
            if (tx_go && tx.last) begin
                tx <= '0;
            end else begin
                tx_idx <= tx.valid ? next_idx : 16'h0000;
                tx.valid <= 1'b1;
                tx.data <= tx.valid ? next_byte : hdr.tid[15:8];
                tx.last <= (tx.valid ? next_idx : 16'h0000) == rsp_len + `MB_LEN_OFS - 16'h0001;
            end
        end
    end

endmodule // mbtcp_server

// ==== hdl/mbtcp_defs.svh ====
`ifndef MBTCP_DEFS_SVH
`define MBTCP_DEFS_SVH

`define MB_HDR_BYTES 16'h0007
`define MB_LEN_OFS 16'h0006
`define MB_PROTO_ID 16'h0000
`define MB_UNIT_ID 8'h00
`define MB_FC_RD_HOLD 8'h03
`define MB_FC_RD_INPUT 8'h04
`define MB_FC_WR_SINGLE 8'h06
`define MB_FC_WR_MULTI 8'h10
`define MB_FC_RW_MULTI 8'h17
`define MB_FC_ENCAP 8'h2B
`define MB_FC_DICT 8'h65
`define MB_FC_ARRAY 8'h66
`define MB_SUB_ENCAP 8'h0D
`define MB_SUB_START 8'h55
`define MB_SUB_NEXT 8'hAA
`define MB_EXC_FLAG 8'h80
`define MB_EXC_FUNC 8'h01
`define MB_EXC_ADDR 8'h02
`define MB_EXC_VALUE 8'h03
`define MB_EXC_FAIL 8'h04
`define MB_REQ_LEN 16'h0006
`define MB_EXC_LEN 16'h0003
`define MB_RD_LEN_BASE 16'h0003
`define MB_RD_MAX 16'h007D
`define MB_CAP_BYTES 4'hC
`define MB_BYTE_TID_HI 16'h0000
`define MB_BYTE_TID_LO 16'h0001
`define MB_BYTE_LEN_HI 16'h0004
`define MB_BYTE_LEN_LO 16'h0005
`define MB_BYTE_FC 16'h0007
`define MB_BYTE_P0 16'h0008
`define MB_BYTE_P1 16'h0009
`define MB_BYTE_P2 16'h000A
`define MB_BYTE_P3 16'h000B

`endif

// ==== hdl/mbtcp_pkg.sv ====
package mbtcp_pkg;

    typedef struct packed {
        logic [15:0] tid;
        logic [15:0] pid;
        logic [15:0] len;
        logic [7:0] uid;
        logic [7:0] fc;
        logic [15:0] word0;
        logic [15:0] word1;
    } mb_hdr_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } mb_byte_t;

    typedef enum {
        ST_IDLE,
        ST_CHECK,
        ST_READ,
        ST_WRITE,
        ST_SEND
    } srv_state_t;

endpackage

// ==== hdl/frame_capture.sv ====
`timescale 1ns/10ps
`include "mbtcp_defs.svh"

module frame_capture
    import mbtcp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire mb_byte_t rx,
    output logic rx_ready,
    input wire logic hold,
    output mb_hdr_t hdr,
    output logic [15:0] nbytes,
    output logic done
);
    logic [15:0] count;
    logic take;

    assign rx_ready = !hold && !done;
    assign take = rx.valid && rx_ready;

    // Byte counter, cleared at each frame end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            count <= 16'h0000;
            nbytes <= 16'h0000;
        end else if (take) begin
            count <= rx.last ? 16'h0000 : count + 16'h0001;
            if (rx.last) begin
                nbytes <= count + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            done <= 1'b0;
        end else begin
            done <= take && rx.last;
        end
    end

    // Header fields are big-endian: high byte first
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hdr <= '0;
        end else if (take && count < 16'(`MB_CAP_BYTES)) begin
            hdr <= mb_hdr_t'({hdr[$bits(mb_hdr_t)-9:0], rx.data});
        end
    end

endmodule // frame_capture

// ==== tb/mbtcp_server_chk.sv ====
`timescale 1ns/10ps
module mbtcp_server_chk
    import mbtcp_pkg::*;
#(
    parameter int MAX_REGS = 125
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire mb_byte_t rx,
    input wire logic rx_ready,
    input wire mb_byte_t tx,
    input wire logic tx_ready,
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic acc_input,
    input wire logic [15:0] acc_addr,
    input wire logic [15:0] acc_wdata,
    input wire logic acc_ack,
    input wire logic acc_err,
    input wire logic acc_pdo,
    input wire logic [15:0] acc_rdata
);
    logic [15:0] idx;
    logic [15:0] lenr;
    logic exc;
    logic take;
    assign take = tx.valid && tx_ready;
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Index of the reply byte on show
    always_ff @(posedge clk_sys) begin
        if (srst) idx <= 16'h0000;
        else if (take) idx <= tx.last ? 16'h0000 : idx + 16'h0001;
    end
    always_ff @(posedge clk_sys) begin
        if (take && idx == 16'h0004) lenr[15:8] <= tx.data;
        if (take && idx == 16'h0005) lenr[7:0] <= tx.data;
        if (take && idx == 16'h0007) exc <= tx.data[7];
    end
    tx_hold_a: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
        else $error("tx byte changed before taken");
    acc_hold_a: assert property (acc_req && !acc_ack |=> acc_req && $stable(acc_addr))
        else $error("access request changed before ack");
    one_client_a: assert property (tx.valid |-> !rx_ready)
        else $error("request taken during reply");
    wr_kind_a: assert property (acc_req && acc_write |-> !acc_input)
        else $error("write flagged as input register");
    pid_zero_a: assert property (tx.valid && idx[15:1] == 15'h0001 |-> tx.data == 8'h00)
        else $error("protocol id not zero");
    uid_zero_a: assert property (tx.valid && idx == 16'h0006 |-> tx.data == 8'h00)
        else $error("unit id not zero");
    len_count_a: assert property (tx.valid && tx.last |-> idx == lenr + 16'h0005)
        else $error("length field does not match reply");
    exc_len_a: assert property (tx.valid && tx.last && exc |-> idx == 16'h0008)
        else $error("exception reply not nine bytes");
endmodule // mbtcp_server_chk

bind mbtcp_server mbtcp_server_chk #(.MAX_REGS(MAX_REGS)) chk (
    .clk_sys(clk_sys), .srst(srst), .rx(rx), .rx_ready(rx_ready), .tx(tx),
    .tx_ready(tx_ready), .acc_req(acc_req), .acc_write(acc_write),
    .acc_input(acc_input), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_ack(acc_ack), .acc_err(acc_err), .acc_pdo(acc_pdo), .acc_rdata(acc_rdata)
);

// ==== tb/obj_store_model.sv ====
`timescale 1ns/10ps
module obj_store_model (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic slow,
    input wire logic acc_req,
    input wire logic acc_write,
    input wire logic acc_input,
    input wire logic [15:0] acc_addr,
    input wire logic [15:0] acc_wdata,
    output logic acc_ack,
    output logic acc_err,
    output logic acc_pdo,
    output logic [15:0] acc_rdata,
    output logic [15:0] last_wdata
);
    logic [1:0] cnt;
    logic [15:0] val;
    // Flags and data are inverted outside the ack cycle
    assign val = acc_addr ^ (acc_input ? 16'hC3C3 : 16'h5A5A);
    assign acc_ack = acc_req && cnt == (slow ? 2'h3 : 2'h0);
    assign acc_pdo = (acc_addr[15:12] == 4'h1) ~^ acc_ack;
    assign acc_err = (acc_addr[15:12] == 4'hF) ~^ acc_ack;
    assign acc_rdata = acc_ack ? val : ~val;
    always_ff @(posedge clk_sys) begin
        if (srst || !acc_req || acc_ack) cnt <= 2'h0;
        else cnt <= cnt + 2'h1;
        if (acc_ack && acc_write) last_wdata <= acc_wdata;
    end
endmodule // obj_store_model

// ==== tb/tb_mbtcp_server.sv ====
`timescale 1ns/10ps
module tb_mbtcp_server
    import mbtcp_pkg::*;
;
    logic clk_sys, srst, tx_ready, slow, rx_ready;
    logic acc_req, acc_write, acc_input, acc_ack, acc_err, acc_pdo;
    logic [15:0] acc_addr, acc_wdata, acc_rdata, last_wdata;
    mb_byte_t rx, tx;
    int err_count, checks;
    logic [7:0] q[$];
    mbtcp_server dut (.clk_sys(clk_sys), .srst(srst), .rx(rx), .rx_ready(rx_ready),
        .tx(tx), .tx_ready(tx_ready), .acc_req(acc_req), .acc_write(acc_write),
        .acc_input(acc_input), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_ack(acc_ack), .acc_err(acc_err), .acc_pdo(acc_pdo), .acc_rdata(acc_rdata));
    obj_store_model store (.clk_sys(clk_sys), .srst(srst), .slow(slow),
        .acc_req(acc_req), .acc_write(acc_write), .acc_input(acc_input),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ack(acc_ack), .acc_err(acc_err),
        .acc_pdo(acc_pdo), .acc_rdata(acc_rdata), .last_wdata(last_wdata));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task stop_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task req(input logic [15:0] tid, pid, input logic [7:0] uid, fc, input logic [15:0] w0, w1);
        logic [7:0] b[12];
        int w;
        b = '{tid[15:8], tid[7:0], pid[15:8], pid[7:0], 8'h00, 8'h06, uid, fc,
            w0[15:8], w0[7:0], w1[15:8], w1[7:0]};
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_sys);
            rx <= '{1'b1, i == 11, b[i]};
            w = 0;
            do begin @(negedge clk_sys); w++; end while (rx_ready !== 1'b1 && w < 100);
            if (rx_ready !== 1'b1) begin err_count++; stop_test(); end
        end
        @(posedge clk_sys);
        rx <= '0;
    endtask
    task get(input logic stall);
        int w;
        q = {};
        w = 0;
        while (w < 3000) begin
            @(negedge clk_sys);
            w++;
            if (tx.valid === 1'b1 && tx_ready) begin
                q.push_back(tx.data);
                if (tx.last === 1'b1) w = 9999;
            end
            @(posedge clk_sys);
            tx_ready <= stall ? ~tx_ready : 1'b1;
        end
        if (w < 9999) begin err_count++; stop_test(); end
    endtask
    task hdr(input logic [15:0] tid, len, input logic [7:0] fc);
        cmp(16'(q.size()), len + 16'h0006);
        cmp({q[0], q[1]}, tid);
        cmp({q[2], q[3]}, 16'h0000);
        cmp({q[4], q[5]}, len);
        cmp({q[6], q[7]}, {8'h00, fc});
    endtask
    task rd(input logic [15:0] tid, input logic [7:0] fc, input logic [15:0] a, n, input logic s);
        req(tid, 16'h0000, 8'h00, fc, a, n);
        get(s);
        hdr(tid, 16'h0003 + (n << 1), fc);
        cmp({8'h00, q[8]}, n << 1);
        for (int i = 0; i < n; i++)
            cmp({q[9 + 2 * i], q[10 + 2 * i]}, 16'(a + i) ^ (fc[2] ? 16'hC3C3 : 16'h5A5A));
    endtask
    task t_write;
        req(16'h1234, 16'h0000, 8'h00, 8'h06, 16'h1770, 16'hFFFF);
        get(1'b0);
        hdr(16'h1234, 16'h0006, 8'h06);
        cmp({q[8], q[9]}, 16'h1770);
        cmp({q[10], q[11]}, 16'hFFFF);
        cmp(last_wdata, 16'hFFFF);
        $display("test write done");
    endtask
    task t_read;
        slow <= 1'b1;
        rd(16'h0101, 8'h03, 16'h1388, 16'h0002, 1'b1);
        slow <= 1'b0;
        rd(16'h0102, 8'h04, 16'h1000, 16'h007D, 1'b0);
        rd(16'h0103, 8'h03, 16'h3001, 16'h0001, 1'b0);
        $display("test read done");
    endtask
    task t_exc;
        logic [55:0] t[13];
        t = '{56'h03138800000003, 56'h041388007E0003, 56'h04138900010002, 56'h03F00000010002,
            56'h06200012340002, 56'h10177000000104, 56'h17177000000104, 56'h2B0D0000000004,
            56'h2B000000000001, 56'h65550000000004, 56'h66AA0000000004, 56'h66000000000001,
            56'h07000000000001};
        for (int i = 0; i < 13; i++) begin
            req(16'(i), 16'h0000, 8'h00, t[i][55:48], t[i][47:32], t[i][31:16]);
            get(1'b0);
            hdr(16'(i), 16'h0003, t[i][55:48] | 8'h80);
            cmp({8'h00, q[8]}, {8'h00, t[i][7:0]});
        end
        $display("test exception done");
    endtask
    task t_drop;
        req(16'h0200, 16'h0001, 8'h00, 8'h03, 16'h1388, 16'h0001);
        repeat (40) begin @(negedge clk_sys); cmp(tx.valid, 1'b0); end
        req(16'h0201, 16'h0000, 8'h01, 8'h03, 16'h1388, 16'h0001);
        repeat (40) begin @(negedge clk_sys); cmp(tx.valid, 1'b0); end
        rd(16'h0202, 8'h03, 16'h1388, 16'h0001, 1'b0);
        $display("test drop done");
    endtask
    initial begin
        rx = '0;
        tx_ready = 1'b1;
        slow = 1'b0;
        srst = 1'b1;
        err_count = 0;
        checks = 0;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        t_write();
        t_read();
        t_exc();
        t_drop();
        stop_test();
    end
endmodule // tb_mbtcp_server
